// ---- logic/pio_port.sv ----
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "pio_cfg.svh"
module pio_port #(
    parameter int NPORT = 8,
    parameter int W     = 8
) (
    // Clock and reset.
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Register bus, write side.
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // Register bus, read side.
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Pins.
    input  wire logic [NPORT*W-1:0]   pin_in,
    output logic [NPORT*W-1:0]        pin_out,
    output logic [NPORT*W-1:0]        pin_oe,
    output logic [NPORT*W-1:0]        pin_pullup,
    // Peripheral sharing and oscillator use.
    input  wire logic [NPORT*W-1:0]   periph_route,
    input  wire logic [NPORT*W-1:0]   periph_out,
    input  wire logic                 osc_unused
);
    logic [NPORT-1:0][W-1:0]  latch_q;
    logic [NPORT-1:0][W-1:0]  dir_q;
    logic [NPORT-1:0][W-1:0]  samp_q;
    logic [NPORT-1:0][W-1:0]  nodrv;
    logic [NPORT-1:0][W-1:0]  rd_port;
    logic [W-1:0]             pu_a_q;
    logic [W-1:0]             pu_b_q;
    wire logic [2*W-1:0]      pu_grp = {pu_b_q, pu_a_q};
    logic                     unlock_q;
    logic [7:0]               awaddr_q;
    logic [31:0]              wdata_q;
    logic                     wstrb0_q;
    logic                     wr_fire;
    logic                     dir0_fire;
    logic                     prot_fire;
    logic [31:0]              rd_val;
    logic                     rd_hit;
    logic [2:0]               wr_idx;
    logic [2:0]               rd_idx;
    pio_pkg::pio_wr_state_t   wr_st_q;

    assign wr_idx = awaddr_q[`PIO_IDX_HI:`PIO_IDX_LO];
    assign rd_idx = s_axi_araddr[`PIO_IDX_HI:`PIO_IDX_LO];
    assign wr_fire = (wr_st_q == pio_pkg::PIO_WR_IDLE) && !s_axi_awready && !s_axi_wready;
    assign dir0_fire = wr_fire && wstrb0_q
                     && (awaddr_q == (`PIO_OFS_DIR | 8'(`PIO_P0_IDX << `PIO_IDX_LO)));
    assign prot_fire = wr_fire && wstrb0_q && (awaddr_q == `PIO_OFS_PROT);

    // Pins with no output stage: absent port 4 bits and the oscillator pair.
    always_comb
    begin
        nodrv = '0;
        nodrv[`PIO_P4_IDX] = ~`PIO_P4_IMPL;
    end

    // Input sampling is the read path; inputs are already synchronous.
    always_ff @(posedge ref_clk)
    begin
        samp_q <= pin_in;
    end

    // Read value per port depends on each bit's direction.
    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            rd_port[p] = (dir_q[p] & latch_q[p]) | (~dir_q[p] & samp_q[p]);
        end
        rd_port[`PIO_P4_IDX] = (rd_port[`PIO_P4_IDX] & `PIO_P4_IMPL)
                             | (samp_q[`PIO_P4_IDX] & `PIO_OSC_MASK & {W{osc_unused}});
    end

    always_comb
    begin
        rd_val = '0;
        rd_hit = 1'b1;
        if (s_axi_araddr[1:0] != 2'b00)
        begin
            rd_hit = 1'b0;
        end
        else if ((s_axi_araddr & `PIO_BANK_MASK) == `PIO_OFS_DATA)
        begin
            rd_val[W-1:0] = rd_port[rd_idx];
        end
        else if ((s_axi_araddr & `PIO_BANK_MASK) == `PIO_OFS_DIR)
        begin
            rd_val[W-1:0] = dir_q[rd_idx];
        end
        else if (s_axi_araddr == `PIO_OFS_PU_A)
        begin
            rd_val[W-1:0] = pu_a_q;
        end
        else if (s_axi_araddr == `PIO_OFS_PU_B)
        begin
            rd_val[W-1:0] = pu_b_q;
        end
        else if (s_axi_araddr == `PIO_OFS_PROT)
        begin
            rd_val[`PIO_UNLOCK_BIT] = unlock_q;
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    // Write channel handshake: address and data are taken in either order.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_st_q       <= pio_pkg::PIO_WR_IDLE;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PIO_RESP_OKAY;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb0_q      <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q      <= s_axi_wdata;
                wstrb0_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            case (wr_st_q)
                pio_pkg::PIO_WR_IDLE:
                begin
                    if (wr_fire)
                    begin
                        wr_st_q      <= pio_pkg::PIO_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= (awaddr_q[1:0] == 2'b00 && awaddr_q <= `PIO_OFS_PROT)
                                        ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
                    end
                end
                pio_pkg::PIO_WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wr_st_q       <= pio_pkg::PIO_WR_IDLE;
                        s_axi_bvalid  <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                    end
                end
                default:
                begin
                    wr_st_q <= pio_pkg::PIO_WR_IDLE;
                end
            endcase
        end
    end

    // Read channel: one cycle from address to data.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `PIO_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Latches keep no reset; they load on every data write with byte 0 strobed, regardless of direction.
    always_ff @(posedge ref_clk)
    begin
        if (wr_fire && wstrb0_q && (awaddr_q & `PIO_BANK_MASK) == `PIO_OFS_DATA)
        begin
            latch_q[wr_idx] <= wdata_q[W-1:0];
        end
    end

    // Direction bits; port 0 is guarded by the unlock bit, absent port 4 bits stay 0.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dir_q <= '0;
        end
        else if (wr_fire && wstrb0_q && (awaddr_q & `PIO_BANK_MASK) == `PIO_OFS_DIR)
        begin
            if (wr_idx == 3'(`PIO_P4_IDX))
            begin
                dir_q[wr_idx] <= wdata_q[W-1:0] & `PIO_P4_IMPL;
            end
            else if (wr_idx != 3'(`PIO_P0_IDX) || unlock_q)
            begin
                dir_q[wr_idx] <= wdata_q[W-1:0];
            end
        end
    end

    // Unlock lasts for exactly one following write; a write that sets it again wins.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            unlock_q <= 1'b0;
        end
        else if (prot_fire)
        begin
            unlock_q <= wdata_q[`PIO_UNLOCK_BIT];
        end
        else if (wr_fire)
        begin
            unlock_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pu_a_q <= `PIO_BYTE_RST;
            pu_b_q <= `PIO_BYTE_RST;
        end
        else if (wr_fire && wstrb0_q && awaddr_q == `PIO_OFS_PU_A)
        begin
            pu_a_q <= wdata_q[W-1:0];
        end
        else if (wr_fire && wstrb0_q && awaddr_q == `PIO_OFS_PU_B)
        begin
            pu_b_q <= wdata_q[W-1:0];
        end
    end

    // Pin stage; pull-ups are shared per four-bit group across both control bytes.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_out    <= '0;
            pin_oe     <= '0;
            pin_pullup <= '0;
        end
        else
        begin
            for (int i = 0; i < NPORT*W; i++)
            begin
                pin_oe[i]     <= (periph_route[i] | dir_q[i/W][i%W]) & ~nodrv[i/W][i%W];
                pin_out[i]    <= periph_route[i] ? periph_out[i] : latch_q[i/W][i%W];
                pin_pullup[i] <= pu_grp[i/4] & ~dir_q[i/W][i%W]
                                 & ~nodrv[i/W][i%W];
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_unlock_armed;
        unlock_q;
    endsequence
    sequence s_dir0_write;
        dir0_fire;
    endsequence

    AST_DIR_DRIVE: assert property (!rst && !$past(rst) |-> pin_oe[7:0] == $past(periph_route[7:0] | dir_q[0])) else $error("Driver enable does not follow direction.");
    AST_SAMPLE: assert property (!$past(rst) |-> samp_q == $past(pin_in)) else $error("Pin sample is stale.");
    AST_READ_SRC: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr == `PIO_OFS_DATA) |=> s_axi_rvalid && s_axi_rdata[W-1:0] == $past(rd_port[0])) else $error("Data read took the wrong source.");
    AST_LATCH: assert property ((wr_fire && wstrb0_q && awaddr_q == `PIO_OFS_DATA) |=> latch_q[0] == $past(wdata_q[W-1:0])) else $error("Latch missed a data write.");
    AST_PERIPH: assert property (periph_route[0] |=> pin_oe[0] && pin_out[0] == $past(periph_out[0])) else $error("Peripheral output not driven.");
    AST_PULLUP: assert property (pin_pullup[0] |-> $past(pu_a_q[0] && !dir_q[0][0])) else $error("Pull-up on without cause.");
    AST_P4_ZERO: assert property ((dir_q[`PIO_P4_IDX] & ~`PIO_P4_IMPL) == '0) else $error("Absent port 4 direction bit set.");
    AST_UNLOCK_WR: assert property (s_unlock_armed ##0 s_dir0_write |=> dir_q[0] == $past(wdata_q[W-1:0]) && !unlock_q) else $error("Unlocked port 0 write lost.");
    AST_LOCKED: assert property ($changed(dir_q[0]) |-> $past(unlock_q && dir0_fire)) else $error("Port 0 direction changed while locked.");
    AST_OSC: assert property (pin_oe[`PIO_P4_IDX*W+7 -: 2] == 2'b00 && pin_pullup[`PIO_P4_IDX*W+7 -: 2] == 2'b00) else $error("Oscillator pin driven or pulled.");
    AST_RESET: assert property ($past(rst) |-> dir_q == '0 && pu_a_q == '0 && pu_b_q == '0 && pin_oe == '0) else $error("Reset left state set.");
endmodule

// ---- logic/pio_cfg.svh ----
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

`define PIO_OFS_DATA    8'h00
`define PIO_OFS_DIR     8'h20
`define PIO_OFS_PU_A    8'h40
`define PIO_OFS_PU_B    8'h44
`define PIO_OFS_PROT    8'h48
`define PIO_BANK_MASK   8'hE0
`define PIO_IDX_HI      4
`define PIO_IDX_LO      2
`define PIO_UNLOCK_BIT  2
`define PIO_P0_IDX      0
`define PIO_P4_IDX      4
`define PIO_P4_IMPL     8'h38
`define PIO_OSC_MASK    8'hC0
`define PIO_BYTE_RST    8'h00
`define PIO_RESP_OKAY   2'b00
`define PIO_RESP_SLVERR 2'b10

`endif

// ---- logic/pio_pkg.sv ----
package pio_pkg;
    typedef enum logic [1:0] {
        PIO_WR_IDLE = 2'b01,
        PIO_WR_RESP = 2'b10
    } pio_wr_state_t;
endpackage

// ---- tb/pio_pins_model.sv ----
`timescale 1ns/1ns
module pio_pins_model (
    // Clock.
    input  wire logic        ref_clk,
    // Drive from the port block.
    input  wire logic [63:0] pin_out,
    input  wire logic [63:0] pin_oe,
    input  wire logic [63:0] pin_pullup,
    // Board sources.
    input  wire logic [63:0] ext_val,
    input  wire logic [63:0] ext_en,
    // Resolved wire levels.
    output logic      [63:0] pin_lvl
);
    logic [63:0] float_q = 64'h5555_5555_5555_5555;

    // A loose wire toggles, so a stale level never passes for a real one.
    always @(posedge ref_clk)
        float_q <= ~float_q;

    // The board drives only pins the block leaves as inputs.
    always_comb
        for (int i = 0; i < 64; i++)
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i]
                       : pin_pullup[i] ? 1'b1 : float_q[i];
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`include "pio_cfg.svh"
module tb_top;
    localparam logic [1:0] OK = `PIO_RESP_OKAY;
    localparam logic [1:0] ER = `PIO_RESP_SLVERR;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  aw_addr = 8'h00;
    logic [7:0]  ar_addr = 8'h00;
    logic [31:0] w_data  = 32'h0000_0000;
    logic        aw_vld  = 1'b0;
    logic        w_vld   = 1'b0;
    logic        b_rdy   = 1'b0;
    logic        ar_vld  = 1'b0;
    logic        r_rdy   = 1'b0;
    logic        osc     = 1'b0;
    logic [63:0] route   = 64'h0;
    logic [63:0] pout    = 64'h0;
    logic [63:0] ext_val = 64'h0000_0000_0000_3C00;
    logic [63:0] ext_en  = 64'h0000_0000_0000_FF00;
    logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
    logic [1:0]  b_resp, r_resp;
    logic [31:0] r_data;
    logic [63:0] p_in, p_out, p_oe, p_pu;
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;

    always #25 ref_clk = ~ref_clk;

    pio_port u_pio_port (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(aw_addr),
        .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy), .s_axi_wdata(w_data),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_rdy),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
        .s_axi_rready(r_rdy), .pin_in(p_in), .pin_out(p_out), .pin_oe(p_oe),
        .pin_pullup(p_pu), .periph_route(route), .periph_out(pout), .osc_unused(osc));

    pio_pins_model u_pio_pins_model (.ref_clk(ref_clk), .pin_out(p_out), .pin_oe(p_oe),
        .pin_pullup(p_pu), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(p_in));

    task automatic finish_test();
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Address and data are offered together and each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        aw_addr <= a;
        w_data <= {24'h00_0000, d};
        aw_vld <= 1'b1;
        w_vld <= 1'b1;
        b_rdy <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge ref_clk);
            if (!aw_done && aw_rdy === 1'b1)
            begin
                aw_done = 1'b1;
                aw_vld <= 1'b0;
            end
            if (!w_done && w_rdy === 1'b1)
            begin
                w_done = 1'b1;
                w_vld <= 1'b0;
            end
        end
        @(posedge ref_clk);
        while (b_vld !== 1'b1)
            @(posedge ref_clk);
        b_rdy <= 1'b0;
        chk(b_resp, resp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] resp);
        @(posedge ref_clk);
        ar_addr <= a;
        ar_vld <= 1'b1;
        r_rdy <= 1'b1;
        @(posedge ref_clk);
        while (ar_rdy !== 1'b1)
            @(posedge ref_clk);
        ar_vld <= 1'b0;
        @(posedge ref_clk);
        while (r_vld !== 1'b1)
            @(posedge ref_clk);
        r_rdy <= 1'b0;
        chk({r_resp, r_data}, {resp, 24'h00_0000, exp});
    endtask

    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic t_reset();
        for (int k = 0; k < 8; k++)
            rd(8'(32 + 4 * k), 8'h00, OK);
        rd(8'h40, 8'h00, OK);
        rd(8'h44, 8'h00, OK);
        chk(p_oe | p_pu, 64'h0);
    endtask

    task automatic t_dir_data();
        wr(8'h04, 8'hA5, OK);
        settle();
        chk(p_oe[15:8], 8'h00);
        rd(8'h04, 8'h3C, OK);
        ext_en <= 64'h0000_0000_0000_F000;
        wr(8'h24, 8'h0F, OK);
        settle();
        chk({p_oe[15:8], p_out[11:8]}, 12'h0F5);
        rd(8'h04, 8'h35, OK);
        wr(8'h40, 8'h0D, OK);
        settle();
        chk(p_pu, 64'h0000_0000_0000_F00F);
    endtask

    // The arm is used up by whatever write comes next, not only a direction write.
    task automatic t_unlock();
        wr(8'h00, 8'h00, OK);
        wr(8'h20, 8'hFF, OK);
        rd(8'h20, 8'h00, OK);
        wr(8'h48, 8'h04, OK);
        rd(8'h48, 8'h04, OK);
        wr(8'h20, 8'hFF, OK);
        rd(8'h20, 8'hFF, OK);
        wr(8'h48, 8'h04, OK);
        wr(8'h00, 8'h00, OK);
        wr(8'h20, 8'h00, OK);
        rd(8'h20, 8'hFF, OK);
        rd(8'h00, 8'h00, OK);
    endtask

    task automatic t_port4();
        wr(8'h10, 8'hFF, OK);
        wr(8'h30, 8'hFF, OK);
        rd(8'h30, 8'h38, OK);
        wr(8'h44, 8'h03, OK);
        osc <= 1'b1;
        ext_val <= 64'h0000_00C0_0000_0000;
        ext_en <= 64'h0000_00C0_0000_0000;
        route <= 64'h0000_00C0_0000_0000;
        pout <= 64'h0000_00C0_0000_0000;
        settle();
        chk({p_oe[39:32], p_pu[39:35]}, 13'h0700);
        rd(8'h10, 8'hF8, OK);
        osc <= 1'b0;
        rd(8'h10, 8'h38, OK);
    endtask

    task automatic t_periph();
        route <= 64'h0000_0000_00FF_0001;
        pout <= 64'h0000_0000_005A_0001;
        settle();
        chk({p_oe[23:16], p_out[23:16]}, 16'hFF5A);
        chk(p_out[0], 1'b1);
        wr(8'h4C, 8'h11, ER);
        rd(8'h4C, 8'h00, ER);
    endtask

    task automatic t_reserved();
        wr(8'h14, 8'h0A, OK);
        wr(8'h34, 8'h1F, OK);
        rd(8'h34, 8'h1F, OK);
        wr(8'h1C, 8'h7F, OK);
        wr(8'h3C, 8'h7F, OK);
        rd(8'h3C, 8'h7F, OK);
        settle();
        chk(p_oe[63:40], 24'h7F_001F);
        chk({p_out[62:56], p_out[44:40]}, 12'hFEA);
    endtask

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            finish_test();
        end
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_dir_data();
        t_unlock();
        t_port4();
        t_periph();
        t_reserved();
        finish_test();
    end
endmodule
